// File: core/lux_limit_consts.vh
// Constants for the light threshold limit register bank
// Summary of operation
// - Lower threshold at 02h, exponent bits 15:12, mantissa 11:0, reset zero.
// - Lower threshold bounds the comparison feeding interrupt and both flags.
// - Upper threshold bounds the comparison feeding interrupt and both flags.
// - Mantissa is unsigned straight binary from zero to exponent full scale.
// - Threshold lux is 0.01 times two to the exponent times mantissa.
// - Exponents 0 to 11 give LSB 0.01 to 20.48 lux.
// - Measurement and thresholds compared in lux, so exponents may differ.
// - Upper threshold at 03h, same layout, resets to BFFFh.
// - Comparison uses the unmasked measurement, ignoring the exponent mask bit.
// - Read-only maker identity register at 7Eh returns a fixed code.
// - Read-only part identity register at 7Fh returns a fixed code.
// - Under-limit flag set after configured consecutive conversions below lower threshold.
// - Fault setting 00,01,10,11 needs one, two, four, eight consecutive events.
`ifndef LUX_LIMIT_CONSTS_VH
`define LUX_LIMIT_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_LOWER         7'h02
`define OFS_UPPER         7'h03
`define OFS_CONTROL       7'h40
`define OFS_STATUS        7'h41
`define OFS_MEAS          7'h42
`define OFS_MAKER         7'h7E
`define OFS_PART          7'h7F

// ****************************************
// Field positions
// ****************************************
`define EXP_MSB           15
`define EXP_LSB           12
`define MAN_MSB           11
`define MAN_LSB           0
`define CTL_FAULT_MSB     1
`define CTL_FAULT_LSB     0
`define CTL_MASK_BIT      2
`define CTL_LATCH_BIT     3
`define CTL_RANGE_MSB     7
`define CTL_RANGE_LSB     4
`define STAT_OVER_BIT     0
`define STAT_UNDER_BIT    1

// ****************************************
// Reset values and fixed codes
// ****************************************
`define LOWER_RESET       16'h0000
`define UPPER_RESET       16'hBFFF
`define CONTROL_RESET     16'h00C8
`define MEAS_RESET        16'h0000
`define RDATA_RESET       16'h0000
`define MAKER_CODE        16'hA5C3 // Arbitrary value
`define PART_CODE         16'h0F1E // Arbitrary value
`define RANGE_AUTO        4'hC
`define EXP_ZERO          4'h0

// ****************************************
// Lux scale and consecutive fault counts
// ****************************************
`define LUX_W             27
`define FAULT_SEL_ONE     2'b00
`define FAULT_SEL_TWO     2'b01
`define FAULT_SEL_FOUR    2'b10
`define FAULT_SEL_EIGHT   2'b11
`define FAULT_CNT_ONE     4'h1
`define FAULT_CNT_TWO     4'h2
`define FAULT_CNT_FOUR    4'h4
`define FAULT_CNT_EIGHT   4'h8

`endif

// File: core/lux_fault_count.v
// Consecutive fault event counter for one comparison direction
`timescale 1ns/1ps
`include "lux_limit_consts.vh"

module lux_fault_count (
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// Conversion events
	input  wire       sample_i,
	input  wire       fault_i,
	input  wire [1:0] setting_i,
	// Result
	output reg        hit_o
);

	reg  [3:0] cnt_reg;
	reg  [3:0] cnt_next;
	reg        hit_next;
	wire [3:0] need;
	wire [3:0] cnt_inc;

	// Number of consecutive faults the setting asks for
	function [3:0] need_count;
		input [1:0] sel;
		begin
			case (sel)
				`FAULT_SEL_ONE:  need_count = `FAULT_CNT_ONE;
				`FAULT_SEL_TWO:  need_count = `FAULT_CNT_TWO;
				`FAULT_SEL_FOUR: need_count = `FAULT_CNT_FOUR;
				default:         need_count = `FAULT_CNT_EIGHT;
			endcase
		end
	endfunction

	assign need    = need_count(setting_i);
	assign cnt_inc = cnt_reg + 4'h1;

	// Count runs of faults; a clean conversion restarts the run
	always @* begin
		cnt_next = cnt_reg;
		hit_next = 1'b0;
		if (sample_i) begin
			if (fault_i) begin
				// Saturate so a lasting fault keeps hitting
				if (cnt_inc >= need) begin
					cnt_next = need;
					hit_next = 1'b1;
				end else begin
					cnt_next = cnt_inc;
				end
			end else begin
				cnt_next = 4'h0;
			end
		end
	end

	// Counter and hit pulse
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 4'h0;
			hit_o   <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			hit_o   <= hit_next;
		end
	end

endmodule // lux_fault_count

// File: core/light_threshold_limit_regs.v
// Threshold and identity registers with lux comparison and limit flags
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "lux_limit_consts.vh"

module light_threshold_limit_regs (
	// Clock and reset
	input  wire        CORE_CLK_I,
	input  wire        RST_I,
	// Register port
	input  wire [6:0]  ADDR_I,
	input  wire [15:0] WDATA_I,
	input  wire        WR_I,
	input  wire        RD_I,
	output reg  [15:0] RDATA_O,
	// Conversion result from the converter
	input  wire [15:0] MEAS_I,
	input  wire        MEAS_VALID_I,
	// Limit reporting
	output reg         OVER_LIMIT_O,
	output reg         UNDER_LIMIT_O,
	output reg         INT_O
);

	// ****************************************
	// Storage
	// ****************************************
	reg  [15:0] lower_reg;
	reg  [15:0] lower_next;
	reg  [15:0] upper_reg;
	reg  [15:0] upper_next;
	reg  [15:0] control_reg;
	reg  [15:0] control_next;
	reg  [15:0] meas_reg;
	reg  [15:0] meas_next;
	reg  [15:0] rdata_next;
	reg         over_flag_reg;
	reg         over_flag_next;
	reg         under_flag_reg;
	reg         under_flag_next;
	reg         int_next;
	reg         sample_reg;
	reg         above_reg;
	reg         below_reg;

	// ****************************************
	// Field views
	// ****************************************
	wire [3:0]  lower_threshold_exponent;
	wire [11:0] lower_threshold_mantissa;
	wire [3:0]  upper_threshold_exponent;
	wire [11:0] upper_threshold_mantissa;
	wire [1:0]  consecutive_fault_setting;
	wire        exponent_mask_bit;
	wire        latch_mode_bit;
	wire [3:0]  range_select_code;
	wire [`LUX_W-1:0] lower_lux;
	wire [`LUX_W-1:0] upper_lux;
	wire [`LUX_W-1:0] meas_lux;
	wire        over_hit;
	wire        under_hit;
	wire        status_rd;
	wire        mask_active;
	reg  [15:0] meas_masked;
	wire        wr_lower;
	wire        wr_upper;
	wire        wr_control;

	// Threshold fields
	assign lower_threshold_exponent  = lower_reg[`EXP_MSB:`EXP_LSB];
	assign lower_threshold_mantissa  = lower_reg[`MAN_MSB:`MAN_LSB];
	assign upper_threshold_exponent  = upper_reg[`EXP_MSB:`EXP_LSB];
	assign upper_threshold_mantissa  = upper_reg[`MAN_MSB:`MAN_LSB];

	// Control fields
	assign consecutive_fault_setting = control_reg[`CTL_FAULT_MSB:`CTL_FAULT_LSB];
	assign exponent_mask_bit         = control_reg[`CTL_MASK_BIT];
	assign latch_mode_bit            = control_reg[`CTL_LATCH_BIT];
	assign range_select_code         = control_reg[`CTL_RANGE_MSB:`CTL_RANGE_LSB];

	// ****************************************
	// Address decode
	// ****************************************

	// One comparator shared by every strobe, so reads and writes see one map
	function offset_hit;
		input [6:0] addr;
		input [6:0] offset;
		begin
			offset_hit = (addr == offset);
		end
	endfunction

	// Write strobes for lower, upper and control plus the status read strobe; status, measurement and identity offsets get no write strobe
	assign wr_lower   = WR_I && offset_hit(ADDR_I, `OFS_LOWER);
	assign wr_upper   = WR_I && offset_hit(ADDR_I, `OFS_UPPER);
	assign wr_control = WR_I && offset_hit(ADDR_I, `OFS_CONTROL);
	assign status_rd  = RD_I && offset_hit(ADDR_I, `OFS_STATUS);

	// ****************************************
	// Lux conversion
	// ****************************************

	// Mantissa shifted by exponent; the common 0.01 lux factor cancels in every
	// comparison, so the integer form orders exactly like the lux values
	function [`LUX_W-1:0] to_lux;
		input [3:0]  expo;
		input [11:0] mant;
		reg   [`LUX_W-1:0] wide;
		begin
			wide   = {{(`LUX_W-12){1'b0}}, mant};
			to_lux = wide << expo;
		end
	endfunction

	// Each operand converted on its own exponent before comparing
	assign lower_lux = to_lux(lower_threshold_exponent, lower_threshold_mantissa);
	assign upper_lux = to_lux(upper_threshold_exponent, upper_threshold_mantissa);
	// Raw measurement always, whatever the mask bit says
	assign meas_lux  = to_lux(MEAS_I[`EXP_MSB:`EXP_LSB], MEAS_I[`MAN_MSB:`MAN_LSB]);

	// Mask only touches the readback copy, with a manual range selected
	assign mask_active = exponent_mask_bit && (range_select_code < `RANGE_AUTO);

	// Exponent forced to zero in the masked copy; the mantissa passes untouched
	always @* begin
		meas_masked = meas_reg;
		if (mask_active) begin
			meas_masked[`EXP_MSB:`EXP_LSB] = `EXP_ZERO;
		end
	end

	// ****************************************
	// Comparison stage
	// ****************************************

	// Conversion strobe, delayed to line up with the registered compare
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			sample_reg <= 1'b0;
		end else begin
			sample_reg <= MEAS_VALID_I;
		end
	end

	// Register the compare so the long shifters do not sit in front of the counters
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			above_reg <= 1'b0;
			below_reg <= 1'b0;
		end else begin
			above_reg <= (meas_lux > upper_lux);
			below_reg <= (meas_lux < lower_lux);
		end
	end

	// ****************************************
	// Consecutive fault counters
	// ****************************************

	// Above the upper bound
	lux_fault_count over_count (
		.clk_i     (CORE_CLK_I),
		.rst_i     (RST_I),
		.sample_i  (sample_reg),
		.fault_i   (above_reg),
		.setting_i (consecutive_fault_setting),
		.hit_o     (over_hit)
	);

	// Below the lower bound
	lux_fault_count under_count (
		.clk_i     (CORE_CLK_I),
		.rst_i     (RST_I),
		.sample_i  (sample_reg),
		.fault_i   (below_reg),
		.setting_i (consecutive_fault_setting),
		.hit_o     (under_hit)
	);

	// ****************************************
	// Limit flags
	// ****************************************

	// Over flag: latched mode holds it until a status read, transparent mode
	// lets an under hit clear it. A set in the clearing cycle always wins.
	always @* begin
		over_flag_next = over_flag_reg;
		if (latch_mode_bit) begin
			if (status_rd) begin
				over_flag_next = 1'b0;
			end
		end else if (under_hit) begin
			over_flag_next = 1'b0;
		end
		if (over_hit) begin
			over_flag_next = 1'b1;
		end
	end

	// Under flag, the mirror image: an over hit clears it in transparent mode
	always @* begin
		under_flag_next = under_flag_reg;
		if (latch_mode_bit) begin
			if (status_rd) begin
				under_flag_next = 1'b0;
			end
		end else if (over_hit) begin
			under_flag_next = 1'b0;
		end
		if (under_hit) begin
			under_flag_next = 1'b1;
		end
	end

	// Pin follows either flag, from the same next values so all three agree
	always @* begin
		int_next = over_flag_next | under_flag_next;
	end

	// Flag state
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			over_flag_reg  <= 1'b0;
			under_flag_reg <= 1'b0;
		end else begin
			over_flag_reg  <= over_flag_next;
			under_flag_reg <= under_flag_next;
		end
	end

	// Pins get their own flops so every output leaves straight from a register
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			OVER_LIMIT_O  <= 1'b0;
			UNDER_LIMIT_O <= 1'b0;
			INT_O         <= 1'b0;
		end else begin
			OVER_LIMIT_O  <= over_flag_next;
			UNDER_LIMIT_O <= under_flag_next;
			INT_O         <= int_next;
		end
	end

	// ****************************************
	// Register writes
	// ****************************************

	// Lower threshold takes the whole word; both fields are host owned
	always @* begin
		lower_next = lower_reg;
		if (wr_lower) begin
			lower_next = WDATA_I;
		end
	end

	// Upper threshold, same layout as the lower one
	always @* begin
		upper_next = upper_reg;
		if (wr_upper) begin
			upper_next = WDATA_I;
		end
	end

	// Control keeps only its low byte; the upper byte reads back zero
	always @* begin
		control_next = control_reg;
		if (wr_control) begin
			control_next = {8'h00, WDATA_I[7:0]};
		end
	end

	// Last conversion, kept for readback only; the compare uses the live feed
	always @* begin
		meas_next = meas_reg;
		if (MEAS_VALID_I) begin
			meas_next = MEAS_I;
		end
	end

	// Lower threshold storage
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			lower_reg <= `LOWER_RESET;
		end else begin
			lower_reg <= lower_next;
		end
	end

	// Upper threshold storage
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			upper_reg <= `UPPER_RESET;
		end else begin
			upper_reg <= upper_next;
		end
	end

	// Control storage
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			control_reg <= `CONTROL_RESET;
		end else begin
			control_reg <= control_next;
		end
	end

	// Measurement copy storage
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			meas_reg <= `MEAS_RESET;
		end else begin
			meas_reg <= meas_next;
		end
	end

	// ****************************************
	// Register reads
	// ****************************************

	// Read data stands only in the cycle after the strobe; unmapped reads zero
	always @* begin
		rdata_next = 16'h0000;
		if (RD_I) begin
			case (ADDR_I)
				`OFS_LOWER:   rdata_next = lower_reg;
				`OFS_UPPER:   rdata_next = upper_reg;
				`OFS_CONTROL: rdata_next = control_reg;
				`OFS_STATUS:  rdata_next = {14'h0000, under_flag_reg, over_flag_reg};
				`OFS_MEAS:    rdata_next = meas_masked;
				`OFS_MAKER:   rdata_next = `MAKER_CODE;
				`OFS_PART:    rdata_next = `PART_CODE;
				default:      rdata_next = 16'h0000;
			endcase
		end
	end

	// Read data register
	always @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			RDATA_O <= `RDATA_RESET;
		end else begin
			RDATA_O <= rdata_next;
		end
	end

endmodule // light_threshold_limit_regs

// File: verif/lux_limit_monitor.sv
// Checker for the threshold and identity register bank
`timescale 1ns/1ps
`include "lux_limit_consts.vh"
module lux_limit_monitor (
	// Clock, reset and register port
	input logic        CORE_CLK_I,
	input logic        RST_I,
	input logic [6:0]  ADDR_I,
	input logic [15:0] WDATA_I,
	input logic        WR_I,
	input logic        RD_I,
	input logic [15:0] RDATA_O,
	// Conversion feed and flags
	input logic [15:0] MEAS_I,
	input logic        MEAS_VALID_I,
	input logic        OVER_LIMIT_O,
	input logic        UNDER_LIMIT_O,
	input logic        INT_O
);
	logic [15:0] lo_reg;
	logic [15:0] hi_reg;
	logic [1:0]  fc_reg;
	logic [26:0] m_lux;
	logic [26:0] lo_lux;
	logic [26:0] hi_lux;
	// ****
	// Shadow limits, so reads are checked raw and compares are judged in lux
	// ****
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			lo_reg <= `LOWER_RESET;
			hi_reg <= `UPPER_RESET;
			fc_reg <= 2'b00;
		end else if (WR_I) begin
			if (ADDR_I == `OFS_LOWER) lo_reg <= WDATA_I;
			if (ADDR_I == `OFS_UPPER) hi_reg <= WDATA_I;
			if (ADDR_I == `OFS_CONTROL) fc_reg <= WDATA_I[1:0];
		end
	end
	assign m_lux = {15'h0000, MEAS_I[11:0]} << MEAS_I[15:12];
	assign lo_lux = {15'h0000, lo_reg[11:0]} << lo_reg[15:12];
	assign hi_lux = {15'h0000, hi_reg[11:0]} << hi_reg[15:12];
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	chk_int_follows: assert property (INT_O == (OVER_LIMIT_O | UNDER_LIMIT_O))
		else $error("interrupt differs from flags");
	chk_read_idle: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
		else $error("read data outside answer cycle");
	chk_maker_code: assert property (RD_I && ADDR_I == `OFS_MAKER |=> RDATA_O == `MAKER_CODE)
		else $error("maker code wrong");
	chk_part_code: assert property (RD_I && ADDR_I == `OFS_PART |=> RDATA_O == `PART_CODE)
		else $error("part code wrong");
	chk_lower_read: assert property (RD_I && ADDR_I == `OFS_LOWER |=> RDATA_O == $past(lo_reg))
		else $error("lower limit readback wrong");
	chk_upper_read: assert property (RD_I && ADDR_I == `OFS_UPPER |=> RDATA_O == $past(hi_reg))
		else $error("upper limit readback wrong");
	chk_under_set: assert property (MEAS_VALID_I && fc_reg == 2'b00 && m_lux < lo_lux |-> ##3 UNDER_LIMIT_O)
		else $error("under flag missing");
	chk_over_set: assert property (MEAS_VALID_I && fc_reg == 2'b00 && m_lux > hi_lux |-> ##3 OVER_LIMIT_O)
		else $error("over flag missing");
	chk_under_cause: assert property ($rose(UNDER_LIMIT_O) |-> $past(MEAS_VALID_I, 3))
		else $error("under flag without conversion");
	cover property ($rose(UNDER_LIMIT_O));
	cover property ($rose(OVER_LIMIT_O));
	cover property (WR_I && ADDR_I == `OFS_MAKER);
endmodule // lux_limit_monitor
bind light_threshold_limit_regs lux_limit_monitor u_lux_limit_monitor (
	.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
	.WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .MEAS_I(MEAS_I),
	.MEAS_VALID_I(MEAS_VALID_I), .OVER_LIMIT_O(OVER_LIMIT_O),
	.UNDER_LIMIT_O(UNDER_LIMIT_O), .INT_O(INT_O));

// File: verif/lux_host.sv
// Host model driving the register port and the conversion feed
`timescale 1ns/1ps
module lux_host (
	// Clock
	input  logic        clk_i,
	// Register port and conversion feed
	output logic [6:0]  addr_o = 7'h00,
	output logic [15:0] wdata_o = 16'h0000,
	output logic        wr_o = 1'b0,
	output logic        rd_o = 1'b0,
	output logic [15:0] meas_o = 16'h0000,
	output logic        mval_o = 1'b0
);
	// ****
	// Transfers; idle lines show inverted data so stale values never match
	// ****
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	task automatic rd(input logic [6:0] a);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
	endtask
	task automatic meas(input logic [15:0] v);
		@(posedge clk_i);
		meas_o <= v;
		mval_o <= 1'b1;
		@(posedge clk_i);
		mval_o <= 1'b0;
		meas_o <= ~v;
	endtask
	// Same range code in both exponents, so only mantissas matter
	task automatic set_window(input logic [3:0] e, input logic [11:0] lm, input logic [11:0] hm);
		wr(7'h02, {e, lm});
		wr(7'h03, {e, hm});
	endtask
endmodule // lux_host

// File: verif/tb.sv
// Self-checking bench for the threshold and identity register bank
`timescale 1ns/1ps
`include "lux_limit_consts.vh"
module tb;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [6:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] meas;
	logic        wr;
	logic        rd;
	logic        mval;
	logic        over_lim;
	logic        under_lim;
	logic        int_pin;
	logic        rd_q = 1'b0;
	logic [15:0] exp_q[$];
	logic [15:0] rnd = 16'h0028;
	int          n_mismatch = 0;
	int          tests_run = 0;
	// Mixed exponents against lower 0400h and upper 0C00h in lux
	logic [15:0] tbl_m[7] = '{16'h11FF, 16'h3080, 16'hB001, 16'h1601, 16'h0C00, 16'hBFFF, 16'h0000};
	logic [15:0] tbl_s[7] = '{16'h0002, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0002};
	always #2.5 core_clk = ~core_clk;
	light_threshold_limit_regs u_light_threshold_limit_regs (
		.CORE_CLK_I(core_clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MEAS_I(meas),
		.MEAS_VALID_I(mval), .OVER_LIMIT_O(over_lim), .UNDER_LIMIT_O(under_lim),
		.INT_O(int_pin));
	lux_host u_lux_host (.clk_i(core_clk), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd), .meas_o(meas), .mval_o(mval));
	// ****
	// Helpers
	// ****
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		tests_run++;
		if (got !== want) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	// Note goes in before the strobe so the watcher always finds it
	task automatic rdx(input logic [6:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		u_lux_host.rd(a);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Answer stands only in the cycle after the strobe
	always @(posedge core_clk) begin
		rd_q <= rd;
		if (rd_q) chk(rdata, exp_q.pop_front());
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		conclude();
	end
	// ****
	// Scenarios
	// ****
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		rdx(`OFS_LOWER, `LOWER_RESET);
		rdx(`OFS_UPPER, `UPPER_RESET);
		u_lux_host.wr(`OFS_MAKER, rnd);
		u_lux_host.wr(`OFS_PART, ~rnd);
		u_lux_host.wr(7'h10, rnd);
		rdx(`OFS_MAKER, `MAKER_CODE);
		rdx(`OFS_PART, `PART_CODE);
		rdx(7'h10, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			u_lux_host.wr(`OFS_LOWER, rnd);
			u_lux_host.wr(`OFS_UPPER, lfsr(rnd));
			rdx(`OFS_LOWER, rnd);
			rdx(`OFS_UPPER, lfsr(rnd));
		end
		$display("test 1 finished");
		// Masked manual range, limits with other exponents
		u_lux_host.wr(`OFS_CONTROL, 16'h000C);
		u_lux_host.wr(`OFS_LOWER, 16'h2100);
		u_lux_host.wr(`OFS_UPPER, 16'h0C00);
		for (int i = 0; i < 7; i++) begin
			u_lux_host.meas(tbl_m[i]);
			repeat (2) @(posedge core_clk);
			#1;
			chk({13'h0, int_pin, under_lim, over_lim}, {13'h0, |tbl_s[i], tbl_s[i][1:0]});
			rdx(`OFS_STATUS, tbl_s[i]);
			rdx(`OFS_MEAS, {4'h0, tbl_m[i][11:0]});
		end
		$display("test 2 finished");
		// Every fault setting: a good conversion restarts the count
		u_lux_host.set_window(4'h0, 12'h800, 12'hF00);
		for (int s = 0; s < 4; s++) begin
			u_lux_host.wr(`OFS_CONTROL, 16'h00C8 | s[15:0]);
			u_lux_host.meas(16'h0900);
			repeat ((1 << s) - 1) u_lux_host.meas(16'h0010);
			u_lux_host.meas(16'h0900);
			repeat ((1 << s) - 1) u_lux_host.meas(16'h0010);
			repeat (2) @(posedge core_clk);
			rdx(`OFS_STATUS, 16'h0000);
			u_lux_host.meas(16'h0010);
			repeat (2) @(posedge core_clk);
			rdx(`OFS_STATUS, 16'h0002);
			rdx(`OFS_STATUS, 16'h0000);
		end
		$display("test 3 finished");
		for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge core_clk);
		if (exp_q.size() > 0) n_mismatch++;
		conclude();
	end
endmodule // tb
